// *** serial_port_pkg.sv ***
// Constants and types for the register control serial port
package serial_port_pkg;

  // ****************************************
  // Identity (values are arbitrary)
  // ****************************************
  localparam logic [7:0] MAIN_ID   = 8'h5c;
  localparam logic [7:0] TEST_ID_A = 8'h6e;
  localparam logic [7:0] TEST_ID_B = 8'ha8;

  // ****************************************
  // Bit counts
  // ****************************************
  localparam logic [3:0] I2C_BYTE_DONE = 4'h8;
  localparam logic [3:0] I2C_ACK_DONE  = 4'h9;
  localparam logic [5:0] SPI_HEAD_BITS = 6'h10;
  localparam logic [5:0] SPI_WORD_BITS = 6'h20;
  localparam logic [5:0] SPI_CNT_MAX   = 6'h3f;
  localparam int         SPI_RW_POS    = 31;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [3:0] {
    I_IDLE, I_ID, I_ADDR_HI, I_ADDR_LO, I_WR_HI, I_WR_LO, I_RD_HI, I_RD_LO, I_WAIT
  } i2c_state_t;

  typedef enum logic [1:0] {
    S_IDLE, S_CMD, S_READ, S_DONE
  } spi_state_t;

endpackage

// *** register_control_serial_port.sv ***
// Serial slave port giving a host access to the 16-bit control registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Two-wire mode only pulls data low; ones are released for the pull-up.
// - Identifier byte low bit is direction: one reads, zero writes.
// - Start condition begins shifting eight identifier bits, MSB first.
// - Matching identifier is acknowledged by holding data low one clock.
// - Mismatch, or read while write-only, sends the port idle until start.
// - Stop condition ends the transfer and returns the port to idle.
// - Start or stop at any unexpected point aborts the transfer.
// - Write is identifier, address high/low, data high/low, each acknowledged.
// - Two-wire multi-register transfers step the address only with auto-increment on.
// - Chip-select word is direction bit, 15 address bits, 16 data bits.
// - Sample data on clock rise; chip-select rise latches last 32 bits.
// - Three-wire reads: master sends header, then device drives data line.
// - Three-wire read data is push-pull or open drain per output setting.
// - Continuous read steps address after each 16-bit data word while select stays low.
// - Readback on configurable pin: low outside reads, or released if wired-OR.
// - Readback on the other pins is always push-pull.
// - Four-wire reads ignore data input after the address, drive readback.
// - Four-wire writes behave exactly like three-wire writes.
// - Mode pin low selects two-wire, high selects chip-select modes.
// - Sixteen-bit addresses in two-wire mode, fifteen-bit in chip-select modes.
// - Four-wire select zero gives shared data line, one gives readback pin.
module register_control_serial_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_clk_en,
  input  wire logic        i_port_protocol_select,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_sda_in,
  input  wire logic        i_auto_inc_enable,
  input  wire logic        i_four_wire_select,
  input  wire logic        i_continuous_readback_enable,
  input  wire logic        i_output_open_drain,
  input  wire logic        i_readback_on_configurable_pin,
  input  wire logic        i_write_only,
  input  wire logic [15:0] i_reg_rdata,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic             o_serial_readback_out,
  output logic             o_serial_readback_oe,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [15:0] o_reg_addr,
  output logic      [15:0] o_reg_wdata
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                            sclk_s1;
    logic                            sclk_s2;
    logic                            sclk_d;
    logic                            sda_s1;
    logic                            sda_s2;
    logic                            sda_d;
    logic                            cs_s1;
    logic                            cs_s2;
    logic                            cs_d;
    logic                            mode_s1;
    logic                            mode_s2;
    serial_port_pkg::i2c_state_t     ist;
    logic [3:0]                      ibit;
    logic [7:0]                      ishift;
    logic [7:0]                      hold_hi;
    serial_port_pkg::spi_state_t     sst;
    logic [5:0]                      scnt;
    logic [31:0]                     sshift;
    logic [15:0]                     rd_shift;
    logic                            load_pend;
    logic [15:0]                     addr;
    logic [15:0]                     wdata;
    logic                            reg_wr;
    logic                            reg_rd;
    logic                            sda_out;
    logic                            sda_oe;
    logic                            rb_out;
    logic                            rb_oe;
  } port_state_t;

  port_state_t r;
  port_state_t n;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction

  function automatic logic id_match(input logic [7:0] id);
    id_match = (id[7:1] == serial_port_pkg::MAIN_ID[7:1]) ||
               (id[7:1] == serial_port_pkg::TEST_ID_A[7:1]) ||
               (id[7:1] == serial_port_pkg::TEST_ID_B[7:1]);
  endfunction

  // Pins {sda_out, sda_oe, rb_out, rb_oe} for a chip-select mode bit
  function automatic logic [3:0] spi_pins(input logic en, input logic b, input logic four,
                                          input logic od, input logic cfg_pin);
    logic [3:0] p;
    p = 4'h0;
    p[0] = ~(cfg_pin & od);
    if (en) begin
      if (four) begin
        p[1] = b;
        p[0] = 1'b1;
      end else begin
        p[3] = od ? 1'b0 : b;
        p[2] = od ? ~b : 1'b1;
      end
    end
    if (!cfg_pin && !en) begin
      p[0] = 1'b1;
    end
    spi_pins = p;
  endfunction

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cond_start;
  logic       cond_stop;
  logic       cs_fall;
  logic       cs_rise;
  logic [7:0] next_shift;
  logic [3:0] rb_bit;
  logic [3:0] pins;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = r;
    n.sclk_s1 = i_sclk;
    n.sclk_s2 = r.sclk_s1;
    n.sclk_d  = r.sclk_s2;
    n.sda_s1  = i_sda_in;
    n.sda_s2  = r.sda_s1;
    n.sda_d   = r.sda_s2;
    n.cs_s1   = i_cs_n;
    n.cs_s2   = r.cs_s1;
    n.cs_d    = r.cs_s2;
    n.mode_s1 = i_port_protocol_select;
    n.mode_s2 = r.mode_s1;
    n.reg_wr  = 1'b0;
    n.reg_rd  = 1'b0;
    // Map answers one cycle after the read strobe
    n.load_pend = r.reg_rd;
    if (r.load_pend) begin
      n.rd_shift = i_reg_rdata;
    end

    sclk_rise  = r.sclk_s2 & ~r.sclk_d;
    sclk_fall  = ~r.sclk_s2 & r.sclk_d;
    cond_start = r.sclk_s2 & r.sclk_d & ~r.sda_s2 & r.sda_d;
    cond_stop  = r.sclk_s2 & r.sclk_d & r.sda_s2 & ~r.sda_d;
    cs_fall    = ~r.cs_s2 & r.cs_d;
    cs_rise    = r.cs_s2 & ~r.cs_d;
    next_shift = {r.ishift[6:0], r.sda_s2};
    rb_bit     = ~r.ibit;
    pins       = 4'h0;

    if (!r.mode_s2) begin
      n.sst    = serial_port_pkg::S_IDLE;
      n.rb_out = 1'b0;
      n.rb_oe  = ~(i_readback_on_configurable_pin & i_output_open_drain);
      n.sda_out = 1'b0;
      if (cond_stop) begin
        n.ist    = serial_port_pkg::I_IDLE;
        n.sda_oe = 1'b0;
      end else if (cond_start) begin
        n.ist    = serial_port_pkg::I_ID;
        n.ibit   = 4'h0;
        n.sda_oe = 1'b0;
      end else if (r.ist != serial_port_pkg::I_IDLE && r.ist != serial_port_pkg::I_WAIT) begin
        if (sclk_rise) begin
          n.ibit = r.ibit + 4'h1;
          if (r.ibit < serial_port_pkg::I2C_BYTE_DONE) begin
            n.ishift = next_shift;
          end else if ((r.ist == serial_port_pkg::I_RD_HI || r.ist == serial_port_pkg::I_RD_LO) && r.sda_s2) begin
            n.ist = serial_port_pkg::I_WAIT;
          end else if (r.ist == serial_port_pkg::I_RD_LO && i_auto_inc_enable) begin
            n.addr   = next_addr(r.addr);
            n.reg_rd = 1'b1;
          end
        end else if (sclk_fall && r.ibit == serial_port_pkg::I2C_BYTE_DONE) begin
          n.sda_oe = 1'b1;
          case (r.ist)
            serial_port_pkg::I_ID: begin
              if (!id_match(r.ishift) || (r.ishift[0] && i_write_only)) begin
                n.ist    = serial_port_pkg::I_IDLE;
                n.sda_oe = 1'b0;
              end else if (r.ishift[0]) begin
                n.reg_rd = 1'b1;
              end
            end
            serial_port_pkg::I_ADDR_HI: n.addr[15:8] = r.ishift;
            serial_port_pkg::I_ADDR_LO: n.addr[7:0]  = r.ishift;
            serial_port_pkg::I_WR_HI:   n.hold_hi    = r.ishift;
            serial_port_pkg::I_WR_LO: begin
              n.wdata  = {r.hold_hi, r.ishift};
              n.reg_wr = 1'b1;
            end
            default: n.sda_oe = 1'b0;
          endcase
        end else if (sclk_fall && r.ibit == serial_port_pkg::I2C_ACK_DONE) begin
          n.sda_oe = 1'b0;
          n.ibit   = 4'h0;
          case (r.ist)
            serial_port_pkg::I_ID:      n.ist = r.ishift[0] ? serial_port_pkg::I_RD_HI : serial_port_pkg::I_ADDR_HI;
            serial_port_pkg::I_ADDR_HI: n.ist = serial_port_pkg::I_ADDR_LO;
            serial_port_pkg::I_ADDR_LO: n.ist = serial_port_pkg::I_WR_HI;
            serial_port_pkg::I_WR_HI:   n.ist = serial_port_pkg::I_WR_LO;
            serial_port_pkg::I_WR_LO: begin
              if (i_auto_inc_enable) begin
                n.addr = next_addr(r.addr);
                n.ist  = serial_port_pkg::I_WR_HI;
              end else begin
                n.ist = serial_port_pkg::I_WAIT;
              end
            end
            serial_port_pkg::I_RD_HI:   n.ist = serial_port_pkg::I_RD_LO;
            serial_port_pkg::I_RD_LO:   n.ist = i_auto_inc_enable ? serial_port_pkg::I_RD_HI : serial_port_pkg::I_WAIT;
            default:                    n.ist = serial_port_pkg::I_IDLE;
          endcase
          if (n.ist == serial_port_pkg::I_RD_HI) begin
            n.sda_oe = ~r.rd_shift[15];
          end else if (n.ist == serial_port_pkg::I_RD_LO) begin
            n.sda_oe = ~r.rd_shift[7];
          end
        end else if (sclk_fall && r.ibit < serial_port_pkg::I2C_BYTE_DONE) begin
          if (r.ist == serial_port_pkg::I_RD_HI) begin
            n.sda_oe = ~r.rd_shift[4'(4'hf - r.ibit)];
          end else if (r.ist == serial_port_pkg::I_RD_LO) begin
            n.sda_oe = ~r.rd_shift[4'(4'h7 - r.ibit)];
          end
        end
      end
    end else begin
      n.ist = serial_port_pkg::I_IDLE;
      if (cs_fall) begin
        n.sst  = serial_port_pkg::S_CMD;
        n.scnt = 6'h00;
      end else if (cs_rise) begin
        if (r.sst == serial_port_pkg::S_CMD && r.scnt >= serial_port_pkg::SPI_WORD_BITS &&
            !r.sshift[serial_port_pkg::SPI_RW_POS]) begin
          n.addr   = {1'b0, r.sshift[30:16]};
          n.wdata  = r.sshift[15:0];
          n.reg_wr = 1'b1;
        end
        n.sst = serial_port_pkg::S_IDLE;
      end else if (!r.cs_s2 && sclk_rise) begin
        if (r.sst == serial_port_pkg::S_CMD) begin
          n.sshift = {r.sshift[30:0], r.sda_s2};
          if (r.scnt != serial_port_pkg::SPI_CNT_MAX) begin
            n.scnt = r.scnt + 6'h01;
          end
          if (n.scnt == serial_port_pkg::SPI_HEAD_BITS && n.sshift[15]) begin
            n.addr   = {1'b0, n.sshift[14:0]};
            n.reg_rd = 1'b1;
            n.sst    = serial_port_pkg::S_READ;
          end
        end else if (r.sst == serial_port_pkg::S_READ) begin
          n.scnt = r.scnt + 6'h01;
          if (n.scnt == serial_port_pkg::SPI_WORD_BITS) begin
            if (i_continuous_readback_enable) begin
              n.addr   = next_addr(r.addr);
              n.reg_rd = 1'b1;
              n.scnt   = serial_port_pkg::SPI_HEAD_BITS;
            end else begin
              n.sst = serial_port_pkg::S_DONE;
            end
          end
        end
      end
      if (r.sst == serial_port_pkg::S_READ) begin
        rb_bit = ~r.scnt[3:0];
      end
      if (cs_rise || r.sst != serial_port_pkg::S_READ || sclk_fall) begin
        pins = spi_pins(r.sst == serial_port_pkg::S_READ && !cs_rise && !r.cs_s2,
                        r.rd_shift[rb_bit], i_four_wire_select,
                        i_output_open_drain, i_readback_on_configurable_pin);
        n.sda_out = pins[3];
        n.sda_oe  = pins[2];
        n.rb_out  = pins[1];
        n.rb_oe   = pins[0];
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      r          <= '0;
      r.ist      <= serial_port_pkg::I_IDLE;
      r.sst      <= serial_port_pkg::S_IDLE;
      r.addr     <= serial_port_pkg::ADDR_RST;
      r.sclk_s1  <= 1'b1;
      r.sclk_s2  <= 1'b1;
      r.sclk_d   <= 1'b1;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
      r.sda_d    <= 1'b1;
      r.cs_s1    <= 1'b1;
      r.cs_s2    <= 1'b1;
      r.cs_d     <= 1'b1;
    end else if (i_clk_en) begin
      r <= n;
    end
  end

  // Outputs come straight from the state register
  assign o_sda_out             = r.sda_out;
  assign o_sda_oe              = r.sda_oe;
  assign o_serial_readback_out = r.rb_out;
  assign o_serial_readback_oe  = r.rb_oe;
  assign o_reg_wr              = r.reg_wr;
  assign o_reg_rd              = r.reg_rd;
  assign o_reg_addr            = r.addr;
  assign o_reg_wdata           = r.wdata;

endmodule // register_control_serial_port

`default_nettype wire

// *** serial_port_monitor.sv ***
// Assertion checker bound to the register control serial port
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module serial_port_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  input wire logic        i_port_protocol_select,
  input wire logic        i_cs_n,
  input wire logic        i_four_wire_select,
  input wire logic        i_output_open_drain,
  input wire logic        i_readback_on_configurable_pin,
  input wire logic        o_sda_out,
  input wire logic        o_sda_oe,
  input wire logic        o_serial_readback_out,
  input wire logic        o_serial_readback_oe,
  input wire logic        o_reg_wr,
  input wire logic        o_reg_rd,
  input wire logic [15:0] o_reg_addr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  AST_TWO_WIRE_NO_HIGH: assert property ((!i_port_protocol_select) [*4] |-> !o_sda_out)
    else $error("data line driven high in two-wire mode");
  AST_CS_WRITE_LATCH: assert property (i_port_protocol_select [*4] ##0 $rose(o_reg_wr) |-> $past(i_cs_n, 2))
    else $error("chip-select write before select rose");
  AST_RD_PULSE: assert property (o_reg_rd |=> !o_reg_rd && $stable(o_reg_addr))
    else $error("read request not a single cycle");
  AST_CS_ADDR_15: assert property (i_port_protocol_select [*4] ##0 (o_reg_wr || o_reg_rd) |-> !o_reg_addr[15])
    else $error("address bit 15 set in chip-select mode");
  AST_RB_IDLE: assert property (((i_cs_n || !i_four_wire_select) && $stable({i_four_wire_select,
    i_output_open_drain, i_readback_on_configurable_pin})) [*8] |-> !o_serial_readback_out &&
    (o_serial_readback_oe == !(i_readback_on_configurable_pin && i_output_open_drain)))
    else $error("readback pin idle level wrong");
  AST_SPI_IDLE_SDA: assert property ((i_port_protocol_select && i_cs_n) [*8] |-> !o_sda_oe)
    else $error("data line driven while deselected");
  AST_FOUR_WIRE_SDA: assert property ((i_port_protocol_select && i_four_wire_select) [*8] |-> !o_sda_oe)
    else $error("data line driven in four-wire mode");
  AST_THREE_WIRE_OD: assert property ((i_port_protocol_select && !i_four_wire_select && i_output_open_drain) [*8]
    ##0 o_sda_oe |-> !o_sda_out)
    else $error("open drain data line driven high");
  COV_WRITE: cover property (o_reg_wr);
  COV_READ: cover property (o_reg_rd && i_port_protocol_select);
  COV_ACK: cover property (o_sda_oe && !i_port_protocol_select);
  COV_RB_ONE: cover property (o_serial_readback_oe && o_serial_readback_out);
endmodule // serial_port_monitor

bind register_control_serial_port serial_port_monitor mon (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_port_protocol_select(i_port_protocol_select), .i_cs_n(i_cs_n), .i_four_wire_select(i_four_wire_select),
  .i_output_open_drain(i_output_open_drain), .i_readback_on_configurable_pin(i_readback_on_configurable_pin),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_serial_readback_out(o_serial_readback_out),
  .o_serial_readback_oe(o_serial_readback_oe), .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd),
  .o_reg_addr(o_reg_addr));
`default_nettype wire

// *** bus_master_model.sv ***
// Host side bus master model driving the serial port pins
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Master model
// ****************************************
module bus_master_model (
  input  wire logic i_sda_line,
  input  wire logic i_rx_line,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_drv,
  output logic      o_val
);
  localparam realtime HALF = 62.5;
  localparam realtime Q    = 31.25;
  // Clock stands still between frames
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_drv = 1'b0;
    o_val = 1'b0;
  end
  // Data moves a quarter period after the fall, so no false start is seen
  task automatic pulse(output logic s);
    #Q o_sclk = 1'b1;
    s = i_rx_line;
    #HALF o_sclk = 1'b0;
    #Q;
  endtask
  task automatic start();
    o_drv = 1'b0;
    #Q o_sclk = 1'b1;
    #Q o_drv = 1'b1;
    o_val = 1'b0;
    #Q o_sclk = 1'b0;
    #Q;
  endtask
  task automatic stop();
    o_drv = 1'b1;
    o_val = 1'b0;
    #Q o_sclk = 1'b1;
    #Q o_drv = 1'b0;
    #HALF;
  endtask
  // byte MSB first, ack on ninth clock
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      o_drv = ~b[i];
      pulse(s);
    end
    o_drv = 1'b0;
    pulse(s);
    ack = ~s;
  endtask
  // read byte, then ack or not-ack
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    o_drv = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    o_drv = ~nack;
    o_val = 1'b0;
    pulse(s);
  endtask
  // master drives header, data phase released or garbled
  task automatic spi_word(input int n, input logic [47:0] w, input logic rd, input logic garble,
                          output logic [47:0] got);
    got = '0;
    o_sclk = 1'b0;
    o_drv = 1'b1;
    #Q o_cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      o_drv = !(rd && k >= 16) || garble;
      o_val = (rd && k >= 16) ? k[0] : w[n - 1 - k];
      pulse(got[n - 1 - k]);
    end
    #Q o_cs_n = 1'b1;
    o_drv = 1'b0;
    #HALF;
  endtask
endmodule // bus_master_model
`default_nettype wire

// *** register_control_serial_port_tb.sv ***
// Self-checking testbench for the register control serial port
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module register_control_serial_port_tb;
  localparam logic [7:0] WID = {serial_port_pkg::MAIN_ID[7:1], 1'b0};
  localparam logic [7:0] RID = {serial_port_pkg::MAIN_ID[7:1], 1'b1};
  logic        i_sys_clk = 1'b0;
  logic        i_srst    = 1'b1;
  logic        sel = 1'b0, fw = 1'b0, od = 1'b0, cfg = 1'b0, contrd = 1'b0, wo = 1'b0, inc = 1'b1;
  logic        sclk, cs_n, drv, val, sda_out, sda_oe, rb_out, rb_oe, reg_wr, reg_rd;
  logic [15:0] reg_addr, reg_wdata;
  logic [31:0] wrq [$];
  int          mismatches  = 0;
  int          checks_done = 0;
  // Pull-up on the data line; every party only pulls or drives when enabled
  wire logic        sda_line = (drv ? val : 1'b1) & (sda_oe ? sda_out : 1'b1);
  wire logic        rx_line  = (sel && fw) ? (rb_oe ? rb_out : 1'b1) : sda_line;
  wire logic [15:0] rdata    = reg_addr ^ 16'h3c5a;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (reg_wr === 1'b1) wrq.push_back({reg_addr, reg_wdata});
  register_control_serial_port dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_clk_en(1'b1),
    .i_port_protocol_select(sel), .i_sclk(sclk), .i_cs_n(cs_n), .i_sda_in(sda_line), .i_auto_inc_enable(inc),
    .i_four_wire_select(fw), .i_continuous_readback_enable(contrd), .i_output_open_drain(od),
    .i_readback_on_configurable_pin(cfg), .i_write_only(wo), .i_reg_rdata(rdata), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_serial_readback_out(rb_out), .o_serial_readback_oe(rb_oe), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));
  bus_master_model m (.i_sda_line(sda_line), .i_rx_line(rx_line), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_drv(drv), .o_val(val));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Order: sel, four-wire, open drain, config pin, continuous, write-only, auto-inc
  task automatic set_mode(input logic [6:0] md);
    @(posedge i_sys_clk);
    #1 {sel, fw, od, cfg, contrd, wo, inc} = md;
    repeat (12) @(posedge i_sys_clk);
  endtask
  task automatic i2c_w(input int n, input logic [55:0] v, output logic [6:0] acks);
    acks = '0;
    m.start();
    for (int i = 0; i < n; i++) m.put_byte(v[55 - 8 * i -: 8], acks[6 - i]);
  endtask
  task automatic t_i2c_write();
    logic [6:0] a;
    for (int k = 1; k >= 0; k--) begin
      set_mode({6'b000000, k[0]});
      wrq.delete();
      i2c_w(7, {WID, 48'h1234_abcd_5678}, a);
      m.stop();
      cmp(a, k ? 7'h7f : 7'h7c);
      cmp(wrq.size(), k ? 2 : 1);
      cmp(wrq[0], 32'h1234_abcd);
      if (k) cmp(wrq[1], 32'h1235_5678);
    end
  endtask
  task automatic t_i2c_ids();
    logic [6:0] a;
    logic [7:0] ids [3] = '{serial_port_pkg::TEST_ID_A, serial_port_pkg::TEST_ID_B, WID ^ 8'h10};
    for (int k = 0; k < 4; k++) begin
      set_mode({5'b00000, k == 3, 1'b1});
      i2c_w(1, {(k == 3) ? RID : (ids[k] & 8'hfe), 48'h0}, a);
      m.stop();
      cmp(a[6], k < 2);
    end
  endtask
  task automatic t_i2c_read();
    logic [6:0]  a;
    logic        b;
    logic [15:0] d;
    // Reads need write-only off; the previous scenario leaves it on
    set_mode(7'b0000001);
    wrq.delete();
    i2c_w(4, {WID, 24'h0042_99, 24'h0}, a);
    m.stop();
    cmp(wrq.size(), 0);
    i2c_w(3, {WID, 16'h0042, 32'h0}, a);
    m.start();
    m.put_byte(RID, b);
    m.get_byte(1'b0, d[15:8]);
    m.get_byte(1'b1, d[7:0]);
    m.stop();
    cmp({a[6:4], b}, 4'hf);
    cmp(d, 16'h3c18);
  endtask
  task automatic t_spi_write();
    logic [47:0] g;
    for (int f = 0; f < 2; f++) begin
      set_mode({1'b1, f[0], 5'b00001});
      wrq.delete();
      m.spi_word(32, {16'h0, 1'b0, 15'h0123, 16'h5a5a}, 1'b0, 1'b0, g);
      m.spi_word(31, {17'h0, 15'h0321, 16'ha5a5}, 1'b0, 1'b0, g);
      cmp(wrq.size(), 1);
      cmp(wrq[0], 32'h0123_5a5a);
    end
  endtask
  task automatic t_spi_read();
    logic [47:0] g;
    for (int k = 0; k < 5; k++) begin
      // Last pass puts readback on another pin with open drain set, which must stay push-pull
      set_mode({1'b1, k > 1, k[0] || k == 4, k < 4, k == 4, 2'b01});
      m.spi_word(k == 4 ? 48 : 32, {1'b1, 15'h0a5c, 32'h0} >> (k == 4 ? 0 : 16), 1'b1, fw, g);
      cmp(g[15:0], k == 4 ? 16'h3607 : 16'h3606);
      if (k == 4) cmp(g[31:16], 16'h3606);
      repeat (10) @(posedge i_sys_clk);
      cmp({rb_oe, rb_out}, {~(cfg & od), 1'b0});
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run takes about 75 us; the limit leaves ample margin
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    #1 i_srst = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    t_i2c_write();
    t_i2c_ids();
    t_i2c_read();
    t_spi_write();
    t_spi_read();
    final_report();
  end
endmodule // register_control_serial_port_tb
`default_nettype wire
